// >>> common/iees_regs.svh
`ifndef IEES_REGS_SVH
`define IEES_REGS_SVH

`define IEES_ADDR_IRQ_EN2      8'h09
`define IEES_ADDR_ERR          8'h0A
`define IEES_ADDR_STATE        8'h0B

`define IEES_EN2_DRIVE_BIT     7
`define IEES_EN2_PIN_BIT       6
`define IEES_EN2_LPD_BIT       5
`define IEES_EN2_RESET         8'h00

`define IEES_ERR_NVM_BIT       7
`define IEES_ERR_WRBUSY_BIT    6
`define IEES_ERR_OVL_BIT       5
`define IEES_ERR_SHORT_BIT     4
`define IEES_ERR_NODATA_BIT    3
`define IEES_ERR_COLL_BIT      2
`define IEES_ERR_PROT_BIT      1
`define IEES_ERR_INTEG_BIT     0
`define IEES_ERR_RESET         8'h00

`define IEES_MIN_FRAME_BITS    4
`define IEES_MIN_EMD_BYTES     3

`define IEES_ST_IDLE           3'h0
`define IEES_ST_TX_WAIT        3'h1
`define IEES_ST_TRANSMIT       3'h3
`define IEES_ST_RX_WAIT        3'h5
`define IEES_ST_WAIT_DATA      3'h6
`define IEES_ST_RECEIVE        3'h7

`endif

// >>> common/iees_pkg.sv
package iees_pkg;

  typedef enum logic [2:0] {
    IEES_IDLE, IEES_TX_WAIT, IEES_TRANSMIT,
    IEES_RX_WAIT, IEES_WAIT_DATA, IEES_RECEIVE
  } iees_link_t;

  // Host register access port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } iees_host_req_t;

  // Receive decoder events, one-cycle pulses
  typedef struct packed {
    logic        sof;
    logic        frame_end;
    logic [15:0] bit_count;
    logic        byte_valid;
    logic        collision;
    logic        coll_in_eof;
    logic [6:0]  coll_pos;
    logic        coll_pos_valid;
    logic        stop_bit_err;
    logic        sof_err;
    logic        byte_count_err;
    logic        parity_err;
    logic        crc_err;
  } iees_rx_evt_t;

  // Command sequencer events
  typedef struct packed {
    logic start_cl_cmd;
    logic start_receive;
    logic start_transceive;
    logic enter_wait_data;
    logic tx_due;
    logic crc_tx;
    logic auth_cmd;
    logic nvm_fault;
    logic multi_err_stored;
  } iees_cmd_evt_t;

endpackage : iees_pkg

// >>> rtl/iees_irq_combine.sv
`include "iees_regs.svh"

module iees_irq_combine #(
  parameter int NUM_TIMERS = 5
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic [7:0]            enable_reg,
  input  wire logic                  low_power_detect_irq,
  input  wire logic [NUM_TIMERS-1:0] tmr_irq,
  input  wire logic                  other_enabled_irq,
  input  wire logic                  combined_clear,
  output logic                       combined_irq_flag,
  output logic                       irq_pin_out,
  output logic                       irq_pin_oe_n
);
  import iees_pkg::*;

  // Elaboration-time guard on the timer count
  if (NUM_TIMERS < 1 || NUM_TIMERS > 5) begin : g_bad_timers
    $error("NUM_TIMERS must be 1 to 5");
  end

  wire logic lpd_req = low_power_detect_irq
                     & enable_reg[`IEES_EN2_LPD_BIT];
  wire logic tmr_req = |(tmr_irq & enable_reg[NUM_TIMERS-1:0]);
  wire logic any_req = lpd_req | tmr_req | other_enabled_irq;
  wire logic pin_lvl = combined_irq_flag
                     & enable_reg[`IEES_EN2_PIN_BIT];

  // Set beats clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      combined_irq_flag <= 1'b0;
    end else if (any_req) begin
      combined_irq_flag <= 1'b1;
    end else if (combined_clear) begin
      combined_irq_flag <= 1'b0;
    end
  end

  // Open drain only pulls low; push-pull drives 1 when asserted, 0 when not
  wire logic push_pull = enable_reg[`IEES_EN2_DRIVE_BIT];
  assign irq_pin_out  = push_pull ? pin_lvl : 1'b0;
  assign irq_pin_oe_n = push_pull ? 1'b0 : ~pin_lvl;

endmodule : iees_irq_combine

// >>> rtl/iees_regs.sv
`include "iees_regs.svh"

module iees_regs #(
  parameter int NUM_TIMERS = 5
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire iees_pkg::iees_host_req_t host_req,
  output logic [7:0]                   host_rdata,
  input  wire iees_pkg::iees_link_t    link_state_in,
  input  wire iees_pkg::iees_rx_evt_t  rx_evt,
  input  wire iees_pkg::iees_cmd_evt_t cmd_evt,
  input  wire logic                    fifo_wr,
  input  wire logic                    fifo_full,
  input  wire logic                    fifo_empty,
  input  wire logic                    fifo_byte_in,
  input  wire logic                    emd_suppress,
  input  wire logic                    collision_as_integrity,
  input  wire logic                    low_power_detect_irq,
  input  wire logic [NUM_TIMERS-1:0]   tmr_irq,
  input  wire logic                    other_enabled_irq,
  input  wire logic                    combined_clear,
  output logic                         fifo_wr_accept,
  output logic                         rx_byte_store,
  output logic                         rx_halt,
  output logic                         receive_decoder_keep,
  output logic                         receive_done_irq,
  output logic                         error_irq_flag,
  output logic [7:0]                   collision_position_reg,
  output logic                         combined_irq_flag,
  output logic                         irq_pin_out,
  output logic                         irq_pin_oe_n
);
  import iees_pkg::*;

  // Elaboration-time guard on the timer count
  if (NUM_TIMERS < 1 || NUM_TIMERS > 5) begin : g_bad_timers
    $error("NUM_TIMERS must be 1 to 5");
  end

  // ==========================================================
  // Functions
  // ==========================================================
  function automatic logic [2:0] state_code(input iees_link_t s);
    case (s)
      IEES_IDLE:      state_code = `IEES_ST_IDLE;
      IEES_TX_WAIT:   state_code = `IEES_ST_TX_WAIT;
      IEES_TRANSMIT:  state_code = `IEES_ST_TRANSMIT;
      IEES_RX_WAIT:   state_code = `IEES_ST_RX_WAIT;
      IEES_WAIT_DATA: state_code = `IEES_ST_WAIT_DATA;
      IEES_RECEIVE:   state_code = `IEES_ST_RECEIVE;
      default:        state_code = `IEES_ST_IDLE;
    endcase
  endfunction : state_code

  // ==========================================================
  // Registers
  // ==========================================================
  logic [7:0] irq_enable_second;
  logic [7:0] contactless_error_flags;
  logic [7:0] transceiver_state;
  logic [7:0] next_err;
  logic       coll_seen;
  logic       coll_seen_sof_ok;

  wire logic wr_en2 = host_req.wr
                    & (host_req.addr == `IEES_ADDR_IRQ_EN2);

  // Error and state addresses are decoded for reads only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_enable_second <= `IEES_EN2_RESET;
    end else if (wr_en2) begin
      irq_enable_second <= host_req.wdata;
    end
  end

  // ==========================================================
  // Event decode
  // ==========================================================
  wire logic in_rx_phase = (link_state_in == IEES_RX_WAIT)
                         | (link_state_in == IEES_WAIT_DATA)
                         | (link_state_in == IEES_RECEIVE);
  wire logic wr_busy_set = fifo_wr
                         & (cmd_evt.crc_tx | in_rx_phase
                            | cmd_evt.auth_cmd);
  wire logic ovl_set = fifo_wr & fifo_full;
  wire logic ovl_now = contactless_error_flags[`IEES_ERR_OVL_BIT];
  assign fifo_wr_accept = fifo_wr & ~fifo_full & ~ovl_now;

  // Decoder bit count saturates far above the short-frame limit
  wire logic short_bits = rx_evt.bit_count < 16'(`IEES_MIN_FRAME_BITS);
  wire logic short_bytes = emd_suppress
    & (rx_evt.bit_count < 16'(`IEES_MIN_EMD_BYTES * 8));
  wire logic frame_short = rx_evt.frame_end & (short_bits | short_bytes);
  wire logic short_set = rx_evt.frame_end & coll_seen_sof_ok
                       & short_bits;

  assign receive_done_irq = rx_evt.frame_end & ~frame_short;
  assign receive_decoder_keep = frame_short;

  wire logic coll_set = rx_evt.collision
                      & ~rx_evt.coll_in_eof;
  wire logic prot_set = rx_evt.stop_bit_err | rx_evt.sof_err
                      | rx_evt.byte_count_err;
  wire logic integ_set = rx_evt.parity_err | rx_evt.crc_err
    | (coll_set & collision_as_integrity);

  assign rx_halt = prot_set;
  // Byte in flight at the fault never reaches the FIFO
  assign rx_byte_store = rx_evt.byte_valid & ~prot_set
    & ~contactless_error_flags[`IEES_ERR_PROT_BIT];

  wire logic rx_clear = cmd_evt.start_receive
                      | cmd_evt.enter_wait_data;
  wire logic wb_clear = cmd_evt.start_cl_cmd
                      | cmd_evt.multi_err_stored;

  // ==========================================================
  // Error flags, set wins over clear
  // ==========================================================
  always_comb begin
    next_err = contactless_error_flags;
    if (cmd_evt.start_cl_cmd) begin
      next_err[`IEES_ERR_NVM_BIT] = 1'b0;
      next_err[`IEES_ERR_NODATA_BIT] = 1'b0;
    end
    if (wb_clear) begin
      next_err[`IEES_ERR_WRBUSY_BIT] = 1'b0;
      next_err[`IEES_ERR_OVL_BIT] = 1'b0;
    end
    if (rx_clear) begin
      next_err[`IEES_ERR_SHORT_BIT] = 1'b0;
      next_err[`IEES_ERR_COLL_BIT] = 1'b0;
      next_err[`IEES_ERR_PROT_BIT] = 1'b0;
      next_err[`IEES_ERR_INTEG_BIT] = 1'b0;
    end
    if (cmd_evt.nvm_fault) begin
      next_err[`IEES_ERR_NVM_BIT] = 1'b1;
    end
    if (wr_busy_set) begin
      next_err[`IEES_ERR_WRBUSY_BIT] = 1'b1;
    end
    if (ovl_set) begin
      next_err[`IEES_ERR_OVL_BIT] = 1'b1;
    end
    if (short_set) begin
      next_err[`IEES_ERR_SHORT_BIT] = 1'b1;
    end
    if (cmd_evt.tx_due & fifo_empty) begin
      next_err[`IEES_ERR_NODATA_BIT] = 1'b1;
    end
    if (coll_set) begin
      next_err[`IEES_ERR_COLL_BIT] = 1'b1;
    end
    if (prot_set) begin
      next_err[`IEES_ERR_PROT_BIT] = 1'b1;
    end
    if (integ_set) begin
      next_err[`IEES_ERR_INTEG_BIT] = 1'b1;
    end
  end

  wire logic [7:0] err_rise = next_err & ~contactless_error_flags;
  assign error_irq_flag = err_rise[`IEES_ERR_WRBUSY_BIT]
                        | err_rise[`IEES_ERR_OVL_BIT]
                        | err_rise[`IEES_ERR_PROT_BIT]
                        | err_rise[`IEES_ERR_NODATA_BIT]
                        | err_rise[`IEES_ERR_INTEG_BIT];

  // Only hardware events write these; host writes never land here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      contactless_error_flags <= `IEES_ERR_RESET;
    end else begin
      contactless_error_flags <= next_err;
    end
  end

  // Valid start of frame seen in the current frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      coll_seen_sof_ok <= 1'b0;
    end else if (rx_evt.sof) begin
      coll_seen_sof_ok <= ~rx_evt.sof_err;
    end else if (rx_evt.frame_end | rx_clear) begin
      coll_seen_sof_ok <= 1'b0;
    end
  end

  // ==========================================================
  // Collision position, first one per reception
  // ==========================================================
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      collision_position_reg <= 8'h00;
      coll_seen <= 1'b0;
    end else if (coll_set & (rx_clear | ~coll_seen)) begin
      collision_position_reg <= {rx_evt.coll_pos_valid,
                                 rx_evt.coll_pos};
      coll_seen <= 1'b1;
    end else if (rx_clear) begin
      collision_position_reg <= 8'h00;
      coll_seen <= 1'b0;
    end
  end

  // ==========================================================
  // State register and read mux
  // ==========================================================
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      transceiver_state <= 8'h00;
    end else begin
      transceiver_state <= {5'h00,
                            state_code(link_state_in)};
    end
  end

  wire logic rd_en2 = host_req.addr == `IEES_ADDR_IRQ_EN2;
  wire logic rd_err = host_req.addr == `IEES_ADDR_ERR;
  wire logic rd_st  = host_req.addr == `IEES_ADDR_STATE;
  wire logic [7:0] rd_mux = rd_en2 ? irq_enable_second
                          : rd_err ? contactless_error_flags
                          : rd_st  ? transceiver_state
                          : 8'h00;

  // Data held until the next read strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      host_rdata <= 8'h00;
    end else if (host_req.rd) begin
      host_rdata <= rd_mux;
    end
  end

  // ==========================================================
  // Interrupt combine
  // ==========================================================
  iees_irq_combine #(
    .NUM_TIMERS (NUM_TIMERS)
  ) u_irq (
    .clk                  (clk),
    .rst                  (rst),
    .enable_reg           (irq_enable_second),
    .low_power_detect_irq (low_power_detect_irq),
    .tmr_irq              (tmr_irq),
    .other_enabled_irq    (other_enabled_irq),
    .combined_clear       (combined_clear),
    .combined_irq_flag    (combined_irq_flag),
    .irq_pin_out          (irq_pin_out),
    .irq_pin_oe_n         (irq_pin_oe_n)
  );

endmodule : iees_regs

// >>> test/iees_regs_assertions.sv
// ====================
// Port checker
module iees_regs_chk #(
  parameter int NUM_TIMERS = 5
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire iees_pkg::iees_host_req_t host_req,
  input  wire logic [7:0]              host_rdata,
  input  wire iees_pkg::iees_link_t    link_state_in,
  input  wire iees_pkg::iees_rx_evt_t  rx_evt,
  input  wire iees_pkg::iees_cmd_evt_t cmd_evt,
  input  wire logic                    fifo_wr,
  input  wire logic                    fifo_empty,
  input  wire logic                    fifo_full,
  input  wire logic                    collision_as_integrity,
  input  wire logic                    low_power_detect_irq,
  input  wire logic [NUM_TIMERS-1:0]   tmr_irq,
  input  wire logic                    other_enabled_irq,
  input  wire logic                    fifo_wr_accept,
  input  wire logic                    rx_byte_store,
  input  wire logic                    rx_halt,
  input  wire logic                    receive_done_irq,
  input  wire logic                    error_irq_flag,
  input  wire logic                    combined_irq_flag,
  input  wire logic                    irq_pin_out,
  input  wire logic                    irq_pin_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  import iees_pkg::*;
  localparam logic [2:0] CMAP [6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
  logic [7:0] en;
  logic       lp;
  logic       req;
  // Shadow of the enable register, rebuilt from host writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en <= 8'h00;
    end else if (host_req.wr && host_req.addr == 8'h09) begin
      en <= host_req.wdata;
    end
  end
  assign lp  = combined_irq_flag & en[6];
  assign req = (low_power_detect_irq & en[5])
             | (|(tmr_irq & en[NUM_TIMERS-1:0]));
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  push_pull_a: assert property (en[7] |->
    !irq_pin_oe_n && irq_pin_out == lp) else $error("push-pull pin");
  open_drain_a: assert property (!en[7] |->
    !irq_pin_out && irq_pin_oe_n == !lp) else $error("open-drain pin");
  pin_gate_a: assert property (!en[6] |->
    (en[7] ? !irq_pin_out : irq_pin_oe_n)) else $error("pin not gated");
  pin_follow_a: assert property ($rose(lp) |->
    (en[7] ? irq_pin_out : !irq_pin_oe_n)) else $error("pin lags");
  irq_set_a: assert property (req |=>
    combined_irq_flag) else $error("combined flag not set");
  irq_mask_a: assert property (!req
    && !combined_irq_flag && !other_enabled_irq && !error_irq_flag
    |=> !combined_irq_flag) else $error("masked request set flag");
  ovl_drop_a: assert property (fifo_wr && fifo_full |->
    !fifo_wr_accept ##1 (!fifo_wr || !fifo_wr_accept))
    else $error("write after overflow kept");
  halt_a: assert property (rx_evt.stop_bit_err ||
    rx_evt.sof_err || rx_evt.byte_count_err |-> rx_halt && !rx_byte_store)
    else $error("protocol fault not halted");
  short_a: assert property (rx_evt.frame_end &&
    rx_evt.bit_count < 16'h0004 |-> !receive_done_irq)
    else $error("short frame raised done");
  err_cause_a: assert property (error_irq_flag |-> fifo_wr ||
    rx_evt.stop_bit_err || rx_evt.sof_err || rx_evt.byte_count_err ||
    rx_evt.parity_err || rx_evt.crc_err || cmd_evt.tx_due && fifo_empty ||
    rx_evt.collision && collision_as_integrity)
    else $error("error irq without cause");
  rdata_hold_a: assert property (!$past(host_req.rd) |->
    $stable(host_rdata)) else $error("read data moved");
  state_code_a: assert property (host_req.rd &&
    host_req.addr == 8'h0B |=> host_rdata[7:3] == 5'h00 &&
    host_rdata[2:0] != 3'h4) else $error("bad state code");
  state_map_a: assert property (!$past(rst) && host_req.rd &&
    host_req.addr == 8'h0B && $stable(link_state_in) |=>
    host_rdata[2:0] == CMAP[$past(link_state_in)])
    else $error("state code mismatch");
endmodule : iees_regs_chk

// >>> test/iees_host_model.sv
// ====================
// Host controller register access
module iees_host_model (
  input  wire logic                     clk,
  output iees_pkg::iees_host_req_t      req,
  input  wire logic [7:0]               rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import iees_pkg::*;
  // Idle cycles before each request, to look like a slow host
  int unsigned idle = 0;
  initial req = '0;
  task automatic access(input logic w, input logic [7:0] a, d,
                        output logic [7:0] q);
    repeat (idle) @(posedge clk);
    @(posedge clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
    #1 q = rdata;
  endtask : access
endmodule : iees_host_model

// >>> test/iees_regs_tb_top.sv
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  n_mismatch++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module iees_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import iees_pkg::*;
  logic           clk = 0;
  logic           rst = 1;
  iees_host_req_t req;
  logic [7:0]     rdata, cpos, q, en;
  iees_link_t     ls = IEES_IDLE;
  iees_rx_evt_t   rx = '0;
  iees_cmd_evt_t  cmd = '0;
  logic           fwr = 0, ffull = 0, fempty = 0, cai = 0, lpd = 0, clr = 0;
  logic [4:0]     tmr = '0;
  logic           emd = 0;
  logic [5:0]     snap;
  logic           acc, store, halt, keep, rdone, eirq, flag, pout, poe_n;
  logic [31:0]    seed = 32'h19;
  int             n_mismatch = 0;
  int             samples_checked = 0;
  localparam logic [7:0] CODES [6] = '{8'h00, 8'h01, 8'h03, 8'h05, 8'h06,
                                       8'h07};
  always #20 clk = ~clk;
  iees_regs u_dut (.clk, .rst, .host_req(req), .host_rdata(rdata),
    .link_state_in(ls), .rx_evt(rx), .cmd_evt(cmd), .fifo_wr(fwr),
    .fifo_full(ffull), .fifo_empty(fempty), .fifo_byte_in(1'b0),
    .emd_suppress(emd), .collision_as_integrity(cai),
    .low_power_detect_irq(lpd), .tmr_irq(tmr), .other_enabled_irq(1'b0),
    .combined_clear(clr), .fifo_wr_accept(acc), .rx_byte_store(store),
    .rx_halt(halt), .receive_decoder_keep(keep), .receive_done_irq(rdone),
    .error_irq_flag(eirq), .collision_position_reg(cpos),
    .combined_irq_flag(flag), .irq_pin_out(pout), .irq_pin_oe_n(poe_n));
  iees_host_model u_host (.clk, .req, .rdata);
  // ====================
  // Helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [1:0] exp_pin(logic [7:0] e, logic f);
    logic a;
    a = f & e[6];
    return e[7] ? {a, 1'b0} : {1'b0, ~a};
  endfunction : exp_pin
  task automatic wr(input logic [7:0] a, d);
    u_host.access(1'b1, a, d, q);
  endtask : wr
  task automatic rdchk(input string n, input logic [7:0] a, e);
    u_host.access(1'b0, a, 8'h00, q);
    `CHK(n, e, q)
  endtask : rdchk
  // One-cycle event; combinational answers caught in that cycle
  task automatic pulse(input iees_rx_evt_t r, input iees_cmd_evt_t c,
                       input logic w);
    @(posedge clk);
    rx <= r;
    cmd <= c;
    fwr <= w;
    #1 snap = {acc, store, halt, keep, rdone, eirq};
    @(posedge clk);
    rx <= '0;
    cmd <= '0;
    fwr <= 1'b0;
  endtask : pulse
  task automatic report_and_stop();
    if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  initial begin
    #400000;
    n_mismatch++;
    report_and_stop();
  end
  // ====================
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdchk("en", 8'h09, 8'h00);
    rdchk("err", 8'h0A, 8'h00);
    rdchk("hole", 8'h3C, 8'h00);
    repeat (4) begin
      en = 8'(xs());
      u_host.idle = xs() % 3;
      wr(8'h09, en);
      wr(8'h0A, ~en);
      wr(8'h0B, ~en);
      rdchk("en", 8'h09, en);
      rdchk("err", 8'h0A, 8'h00);
      rdchk("st", 8'h0B, 8'h00);
    end
    for (int i = 0; i < 6; i++) begin
      for (int k = 0; k < 2; k++) begin
        en = (8'(xs()) & 8'hC0) | (k ? 8'h01 << i : 8'h00);
        wr(8'h09, en);
        @(posedge clk);
        {lpd, tmr} <= 6'h01 << i;
        @(posedge clk);
        {lpd, tmr} <= 6'h00;
        #1 `CHK("flag", 1'(k), flag)
        `CHK("pin", exp_pin(en, 1'(k)), {pout, poe_n})
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
      end
    end
    // Fault flags, all set then cleared in their groups
    @(posedge clk);
    ls <= IEES_RECEIVE;
    fempty <= 1'b1;
    pulse('{default: 0, parity_err: 1}, '0, 0);
    `CHK("integ", 6'h01, snap)
    pulse('{default: 0, collision: 1, coll_pos_valid: 1, coll_pos: 7'h15},
          '0, 0);
    pulse('{default: 0, collision: 1, coll_pos_valid: 1, coll_pos: 7'h20},
          '0, 0);
    `CHK("cpos", 8'h95, cpos)
    pulse('{default: 0, byte_valid: 1, stop_bit_err: 1}, '0, 0);
    `CHK("halt", 6'h09, snap)
    pulse('{default: 0, sof: 1}, '0, 0);
    pulse('{default: 0, frame_end: 1, bit_count: 16'h0002}, '0, 0);
    `CHK("short", 6'h04, snap)
    pulse('0, '{default: 0, nvm_fault: 1, tx_due: 1}, 1);
    @(posedge clk);
    ffull <= 1'b1;
    pulse('0, '0, 1);
    @(posedge clk);
    ffull <= 1'b0;
    pulse('0, '0, 1);
    `CHK("drop", 6'h00, snap)
    wr(8'h0A, 8'h00);
    rdchk("err", 8'h0A, 8'hFF);
    pulse('0, '{default: 0, start_cl_cmd: 1}, 0);
    rdchk("err", 8'h0A, 8'h17);
    pulse('0, '{default: 0, enter_wait_data: 1}, 0);
    rdchk("err", 8'h0A, 8'h00);
    pulse('{default: 0, collision: 1, coll_in_eof: 1}, '0, 1);
    pulse('0, '{default: 0, multi_err_stored: 1}, 0);
    rdchk("err", 8'h0A, 8'h00);
    @(posedge clk);
    cai <= 1'b1;
    pulse('{default: 0, collision: 1}, '0, 0);
    rdchk("err", 8'h0A, 8'h05);
    pulse('0, '{default: 0, start_receive: 1}, 0);
    rdchk("err", 8'h0A, 8'h00);
    pulse('{default: 0, byte_valid: 1, frame_end: 1, bit_count: 16'h0004},
          '0, 0);
    `CHK("done", 6'h12, snap)
    // Two bytes under EMD suppression: dropped, no done, no flag
    @(posedge clk);
    emd <= 1'b1;
    pulse('{default: 0, sof: 1}, '0, 0);
    pulse('{default: 0, frame_end: 1, bit_count: 16'h0010}, '0, 0);
    `CHK("emd", 6'h04, snap)
    rdchk("err", 8'h0A, 8'h00);
    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      ls <= iees_link_t'(k);
      rdchk("state", 8'h0B, CODES[k]);
    end
    // Mid-run reset must bring the enable and error registers back to zero
    wr(8'h09, 8'hE1);
    pulse('{default: 0, parity_err: 1}, '0, 0);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rdchk("en", 8'h09, 8'h00);
    rdchk("err", 8'h0A, 8'h00);
    report_and_stop();
  end
endmodule : iees_regs_tb_top
bind iees_regs iees_regs_chk #(.NUM_TIMERS(NUM_TIMERS)) u_chk (.clk, .rst,
  .host_req, .host_rdata, .link_state_in, .rx_evt, .cmd_evt, .fifo_wr,
  .fifo_empty, .fifo_full, .collision_as_integrity, .low_power_detect_irq,
  .tmr_irq, .other_enabled_irq, .fifo_wr_accept, .rx_byte_store, .rx_halt,
  .receive_done_irq, .error_irq_flag, .combined_irq_flag, .irq_pin_out,
  .irq_pin_oe_n);
